// ===== rtl/ccth_timer.sv
// 16-bit free-running timer with two captures, two compares, one-pulse and
// PWM modes, a prescaler or external count input, and halt/wait behaviour.
// Assumes all pin inputs are synchronous to sys_clk_i and that the CPU issues
// no register access while halt_i is high.
//
// The implementer's own choices: strobed register access and the register offsets.

// Function
// R1 - Timer runs in wait; interrupt wakes device
// R2 - Halt freezes counter; resume from held count
// R3 - Capture edge in halt armed, stored at exit
// R4 - No halt wake; one gated common interrupt
// R5 - Control one bits 7,6,5 enable interrupts
// R6 - Force bits copy levels to enabled pins
// R7 - Level two on compare two match
// R8 - Level one on compare one match
// R9 - Capture edge select: 0 falling, 1 rising
// R10 - Pin enables route output only
// R11 - One-pulse: capture one edge triggers pulse
// R12 - PWM: compare one width, compare two period
// R13 - Clock select: div4, div2, div8, external
// R14 - Without external pin, external select stops
// R15 - External edge select: 0 falling, 1 rising
// R16 - Capture flags set by captures, PWM period
// R17 - Compare flags set on counter match
// R18 - Flags cleared by status read then low-byte access
// R19 - Overflow on wrap, cleared via counter low only
// R20 - Disable bit freezes counter, kills outputs; one-pulse trigger still reloads counter
// R21 - Software writes zeros to reserved status bits
// R22 - PWM sets no compare flags; modes claim resources
// R23 - One-pulse trigger, PWM period reload FFFC
// R24 - PWM compare writes take effect at period end
// R25 - Counter low write resets counter
// R26 - Capture one high returns latched upper byte
module ccth_timer #(
   parameter int HAS_EXT_PIN = 1
) (
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_i,
   input  wire logic [ccth_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [ccth_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                       we_i,
   input  wire logic                       re_i,
   output logic      [ccth_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                       halt_i,
   input  wire logic                       irq_mask_i,
   input  wire logic                       capture_input_one_i,
   input  wire logic                       capture_input_two_i,
   input  wire logic                       external_count_input_i,
   output logic                            compare_output_one_o,
   output logic                            compare_output_one_oe_o,
   output logic                            compare_output_two_o,
   output logic                            compare_output_two_oe_o,
   output logic                            irq_o,
   output logic                            wake_o
);
   import ccth_pkg::*;

   if (HAS_EXT_PIN != 0 && HAS_EXT_PIN != 1) begin : g_chk
      $error("HAS_EXT_PIN must be 0 or 1");
   end

   logic [DATA_W-1:0] ctrl_one_q;
   logic [DATA_W-1:0] ctrl_two_q;
   logic              timer_disable_q;
   logic [FLAG_N-1:0] flag_q;
   logic [FLAG_N-1:0] arm_q;
   logic [FLAG_N-1:0] flag_set;
   logic [FLAG_N-1:0] flag_clr;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cmp1_w_q;
   logic [CNT_W-1:0]  cmp2_w_q;
   logic [CNT_W-1:0]  cmp1_q;
   logic [CNT_W-1:0]  cmp2_q;
   logic [CNT_W-1:0]  cap1_q;
   logic [CNT_W-1:0]  cap2_q;
   logic [1:0]        cmp_inh_q;
   logic [2:0]        presc_q;
   logic [2:0]        presc_last;
   logic              cap1_prev_q;
   logic              cap2_prev_q;
   logic              ext_prev_q;
   logic              halt_prev_q;
   logic [1:0]        halt_arm_q;
   logic              lvl1_q;
   logic              lvl2_q;
   logic [DATA_W-1:0] rdata_q;
   ccth_mode_t        mode;
   logic              run;
   logic              tick;
   logic              edge1;
   logic              edge2;
   logic              ext_edge;
   logic              halt_exit;
   logic              cnt_wr;
   logic              opm_trig;
   logic              period_end;
   logic              match1;
   logic              match2;
   logic              cap1_evt;
   logic              cap2_evt;
   logic              ovf_evt;
   logic              irq_pend;
   logic [1:0]        clk_sel;

   assign clk_sel = ctrl_two_q[C2_CLK_HI:C2_CLK_LO];

   // PWM takes precedence when both mode bits are set.
   always_comb begin
      if (ctrl_two_q[C2_PWM]) begin
         mode = CCTH_MODE_PWM;
      end else if (ctrl_two_q[C2_ONE_PLS]) begin
         mode = CCTH_MODE_ONE_PULSE;
      end else begin
         mode = CCTH_MODE_NORMAL;
      end
   end

   assign run       = !halt_i && !timer_disable_q; // see R2 see R20
   assign halt_exit = halt_prev_q && !halt_i;
   assign cnt_wr    = we_i && (addr_i == ADDR_CNT_LO || addr_i == ADDR_ALT_LO); // see R25

   // see R9 see R15
   assign edge1    = ctrl_one_q[C1_EDGE1] ? (capture_input_one_i && !cap1_prev_q)
                                          : (!capture_input_one_i && cap1_prev_q);
   assign edge2    = ctrl_two_q[C2_EDGE2] ? (capture_input_two_i && !cap2_prev_q)
                                          : (!capture_input_two_i && cap2_prev_q);
   assign ext_edge = ctrl_two_q[C2_EXT_EDG] ? (external_count_input_i && !ext_prev_q)
                                            : (!external_count_input_i && ext_prev_q);

   always_comb begin
      unique case (clk_sel)
         CLK_DIV2: presc_last = DIV2_LAST;
         CLK_DIV8: presc_last = DIV8_LAST;
         default:  presc_last = DIV4_LAST;
      endcase
   end

   // The external setting stops the counter on a part without the pin.
   assign tick = run && ((clk_sel == CLK_EXT) ? (HAS_EXT_PIN == 1 && ext_edge) // see R13 see R14
                                              : (presc_q >= presc_last));

   assign opm_trig   = mode == CCTH_MODE_ONE_PULSE && edge1 && !halt_i; // see R11
   // A compare is inhibited between a high-byte write and its low-byte write.
   assign match1     = tick && !cmp_inh_q[0] && cnt_q == cmp1_q;
   assign match2     = tick && !cmp_inh_q[1] && cnt_q == cmp2_q;
   assign period_end = mode == CCTH_MODE_PWM && match2;
   assign cap1_evt   = mode == CCTH_MODE_NORMAL && ((edge1 && !halt_i) || (halt_exit && halt_arm_q[0])); // see R3
   assign cap2_evt   = (edge2 && !halt_i) || (halt_exit && halt_arm_q[1]);
   assign ovf_evt    = tick && cnt_q == CNT_MAX && !period_end && !opm_trig && !cnt_wr; // see R19

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cap1_prev_q <= 1'b0;
         cap2_prev_q <= 1'b0;
         ext_prev_q  <= 1'b0;
         halt_prev_q <= 1'b0;
      end else begin
         cap1_prev_q <= capture_input_one_i;
         cap2_prev_q <= capture_input_two_i;
         ext_prev_q  <= external_count_input_i;
         halt_prev_q <= halt_i;
      end
   end

   // The prescaler stands still whenever the counter is frozen.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         presc_q <= 3'h0;
      end else if (run) begin // see R20
         presc_q <= (presc_q >= presc_last) ? 3'h0 : presc_q + 3'h1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= CNT_RESET;
      end else if (cnt_wr) begin
         cnt_q <= CNT_RESET; // see R25
      end else if (opm_trig || period_end) begin
         cnt_q <= CNT_RESET; // see R23
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Edges seen while halted are remembered and resolved at halt exit.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         halt_arm_q <= 2'h0;
      end else if (halt_i) begin
         if (edge1 && mode == CCTH_MODE_NORMAL) begin
            halt_arm_q[0] <= 1'b1; // see R3
         end
         if (edge2) begin
            halt_arm_q[1] <= 1'b1;
         end
      end else begin
         halt_arm_q <= 2'h0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cap1_q <= CAP_RESET;
         cap2_q <= CAP_RESET;
      end else begin
         if (opm_trig) begin
            cap1_q <= CAP_OPM_VALUE;
         end else if (cap1_evt) begin
            cap1_q <= cnt_q; // see R26
         end
         if (cap2_evt) begin
            cap2_q <= cnt_q;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_one_q <= CTRL_RESET;
         ctrl_two_q <= CTRL_RESET;
         timer_disable_q     <= 1'b0;
      end else if (we_i) begin
         if (addr_i == ADDR_CTRL_ONE) begin
            ctrl_one_q <= wdata_i;
         end
         if (addr_i == ADDR_CTRL_TWO) begin
            ctrl_two_q <= wdata_i;
         end
         if (addr_i == ADDR_STATUS) begin
            timer_disable_q <= wdata_i[ST_DISABLE]; // see R20
         end
      end
   end

   // Software values land in the write buffers; outside PWM they are copied
   // every cycle, in PWM only at the period end so no spike reaches the pin.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp1_w_q  <= CMP_RESET;
         cmp2_w_q  <= CMP_RESET;
         cmp_inh_q <= 2'h0;
      end else if (we_i) begin
         unique case (addr_i)
            ADDR_CMP1_HI: begin
               cmp1_w_q[CNT_W-1:DATA_W] <= wdata_i;
               cmp_inh_q[0]             <= 1'b1;
            end
            ADDR_CMP1_LO: begin
               cmp1_w_q[DATA_W-1:0] <= wdata_i;
               cmp_inh_q[0]         <= 1'b0;
            end
            ADDR_CMP2_HI: begin
               cmp2_w_q[CNT_W-1:DATA_W] <= wdata_i;
               cmp_inh_q[1]             <= 1'b1;
            end
            ADDR_CMP2_LO: begin
               cmp2_w_q[DATA_W-1:0] <= wdata_i;
               cmp_inh_q[1]         <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp1_q <= CMP_RESET;
         cmp2_q <= CMP_RESET;
      end else if (mode != CCTH_MODE_PWM || period_end) begin // see R24
         cmp1_q <= cmp1_w_q;
         cmp2_q <= cmp2_w_q;
      end
   end

   // see R16 see R17 see R22
   assign flag_set[F_CAP1] = cap1_evt || opm_trig || period_end;
   assign flag_set[F_CMP1] = match1 && mode == CCTH_MODE_NORMAL;
   assign flag_set[F_OVF]  = ovf_evt;
   assign flag_set[F_CAP2] = cap2_evt;
   assign flag_set[F_CMP2] = match2 && mode != CCTH_MODE_PWM;

   // Only the primary counter low byte clears overflow; the alternate does not.
   assign flag_clr[F_CAP1] = addr_i == ADDR_CAP1_LO;
   assign flag_clr[F_CMP1] = addr_i == ADDR_CMP1_LO;
   assign flag_clr[F_OVF]  = addr_i == ADDR_CNT_LO; // see R19
   assign flag_clr[F_CAP2] = addr_i == ADDR_CAP2_LO;
   assign flag_clr[F_CMP2] = addr_i == ADDR_CMP2_LO;

   // A status read while a flag is set arms it; the next access to its low
   // byte clears it. A new event in the clearing cycle keeps the flag set.
   for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
         if (rst_i) begin
            flag_q[i] <= 1'b0;
            arm_q[i]  <= 1'b0;
         end else begin
            if (flag_set[i]) begin
               flag_q[i] <= 1'b1;
            end else if (arm_q[i] && (we_i || re_i) && flag_clr[i]) begin
               flag_q[i] <= 1'b0; // see R18
            end
            if (re_i && addr_i == ADDR_STATUS) begin
               arm_q[i] <= flag_q[i];
            end else if ((we_i || re_i) && flag_clr[i]) begin
               arm_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lvl1_q <= 1'b0;
      end else begin
         unique case (mode)
            CCTH_MODE_NORMAL: begin
               if (ctrl_one_q[C1_FORCE1] || match1) begin
                  lvl1_q <= ctrl_one_q[C1_LEVEL1]; // see R6 see R8
               end
            end
            CCTH_MODE_ONE_PULSE: begin
               if (opm_trig) begin
                  lvl1_q <= ctrl_one_q[C1_LEVEL2]; // see R7 see R11
               end else if (match1) begin
                  lvl1_q <= ctrl_one_q[C1_LEVEL1];
               end
            end
            CCTH_MODE_PWM: begin
               if (period_end) begin
                  lvl1_q <= ctrl_one_q[C1_LEVEL2]; // see R7 see R12
               end else if (match1) begin
                  lvl1_q <= ctrl_one_q[C1_LEVEL1];
               end
            end
         endcase
      end
   end

   // Level two belongs to the first pin in both special modes.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lvl2_q <= 1'b0;
      end else if (mode == CCTH_MODE_NORMAL && (ctrl_one_q[C1_FORCE2] || match2)) begin
         lvl2_q <= ctrl_one_q[C1_LEVEL2]; // see R6 see R7
      end
   end

   // The enables only steer the pins; the compare logic runs regardless.
   assign compare_output_one_o    = lvl1_q;
   assign compare_output_two_o    = lvl2_q;
   assign compare_output_one_oe_o = ctrl_two_q[C2_PIN1_EN] && !timer_disable_q; // see R10 see R20
   assign compare_output_two_oe_o = ctrl_two_q[C2_PIN2_EN] && !timer_disable_q; // see R10 see R20

   // see R5
   assign irq_pend = (ctrl_one_q[C1_CAP_IE] && (flag_q[F_CAP1] || flag_q[F_CAP2]))
                  || (ctrl_one_q[C1_CMP_IE] && (flag_q[F_CMP1] || flag_q[F_CMP2]))
                  || (ctrl_one_q[C1_OVF_IE] && flag_q[F_OVF]);
   assign irq_o    = irq_pend && !irq_mask_i; // see R4
   assign wake_o   = irq_o && !halt_i; // see R1 see R4

   // Reserved status bits read as zero whatever software wrote.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (re_i) begin
         unique case (addr_i)
            ADDR_CTRL_ONE: rdata_q <= ctrl_one_q;
            ADDR_CTRL_TWO: rdata_q <= ctrl_two_q;
            ADDR_STATUS:   rdata_q <= {flag_q, timer_disable_q, 2'h0}; // see R21
            ADDR_CAP1_HI:  rdata_q <= cap1_q[CNT_W-1:DATA_W]; // see R26
            ADDR_CAP1_LO:  rdata_q <= cap1_q[DATA_W-1:0];
            ADDR_CMP1_HI:  rdata_q <= cmp1_w_q[CNT_W-1:DATA_W];
            ADDR_CMP1_LO:  rdata_q <= cmp1_w_q[DATA_W-1:0];
            ADDR_CNT_HI:   rdata_q <= cnt_q[CNT_W-1:DATA_W];
            ADDR_CNT_LO:   rdata_q <= cnt_q[DATA_W-1:0];
            ADDR_ALT_HI:   rdata_q <= cnt_q[CNT_W-1:DATA_W];
            ADDR_ALT_LO:   rdata_q <= cnt_q[DATA_W-1:0];
            ADDR_CAP2_HI:  rdata_q <= cap2_q[CNT_W-1:DATA_W];
            ADDR_CAP2_LO:  rdata_q <= cap2_q[DATA_W-1:0];
            ADDR_CMP2_HI:  rdata_q <= cmp2_w_q[CNT_W-1:DATA_W];
            ADDR_CMP2_LO:  rdata_q <= cmp2_w_q[DATA_W-1:0];
            default:       rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_o = rdata_q;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_ovf_arm;
      re_i && addr_i == ADDR_STATUS && flag_q[F_OVF];
   endsequence

   sequence s_ovf_clear_access;
      (re_i || we_i) && addr_i == ADDR_CNT_LO && !ovf_evt;
   endsequence

   AST_TWO_STEP_CLEAR: assert property (s_ovf_arm ##1 s_ovf_clear_access |=> !flag_q[F_OVF]) // see R18
      else $error("overflow flag survived the two-step clear");

   AST_ALT_NO_CLEAR: assert property (flag_q[F_OVF] && (re_i || we_i) && addr_i == ADDR_ALT_LO |=> flag_q[F_OVF]) // see R19
      else $error("alternate counter access cleared overflow");

   AST_OVF_SET: assert property (ovf_evt |=> flag_q[F_OVF] && cnt_q == 16'h0000) // see R19
      else $error("wrap did not set overflow or reach zero");

   AST_HALT_FREEZE: assert property (halt_i && !cnt_wr |=> cnt_q == $past(cnt_q)) // see R2
      else $error("counter moved during halt");

   AST_HALT_NO_WAKE: assert property (halt_i |-> !wake_o) // see R4
      else $error("timer woke the device from halt");

   AST_DISABLE_OUT: assert property (timer_disable_q |-> !compare_output_one_oe_o && !compare_output_two_oe_o) // see R20
      else $error("outputs driven while timer disabled");

   AST_DISABLE_FREEZE: assert property (timer_disable_q && !cnt_wr && !opm_trig ##1 timer_disable_q |-> cnt_q == $past(cnt_q)) // see R20
      else $error("counter moved while disabled");

   AST_OPM_RELOAD: assert property (opm_trig && !cnt_wr |=> cnt_q == CNT_RESET && lvl1_q == $past(ctrl_one_q[C1_LEVEL2])) // see R23
      else $error("one-pulse trigger did not reload and start pulse");

   AST_PWM_NO_CMP_FLAG: assert property ((mode == CCTH_MODE_PWM && !flag_q[F_CMP1]) ##1 (mode == CCTH_MODE_PWM) |-> !flag_q[F_CMP1]) // see R22
      else $error("compare flag set in PWM mode");

   AST_DIV2_RATE: assert property (run && clk_sel == CLK_DIV2 && tick ##1 (run && clk_sel == CLK_DIV2) |-> !tick) // see R13
      else $error("divide-by-two ticked twice in a row");

   AST_IRQ_OVF: assert property (flag_q[F_OVF] && ctrl_one_q[C1_OVF_IE] && !irq_mask_i |-> irq_o) // see R5
      else $error("enabled overflow raised no interrupt");

endmodule

// ===== rtl/ccth_pkg.sv
// Constants shared by the 16-bit capture/compare timer: register offsets,
// field positions, reset values, clock selections and operating modes.
// Assumes an 8-bit register port with a 4-bit register index.
package ccth_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 16;
   localparam int FLAG_N = 5;

   // Register indexes on the register port.
   localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_CAP1_HI  = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_CAP1_LO  = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_CMP1_HI  = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_CMP1_LO  = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_CNT_HI   = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_CNT_LO   = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_ALT_HI   = 4'hA;
   localparam logic [ADDR_W-1:0] ADDR_ALT_LO   = 4'hB;
   localparam logic [ADDR_W-1:0] ADDR_CAP2_HI  = 4'hC;
   localparam logic [ADDR_W-1:0] ADDR_CAP2_LO  = 4'hD;
   localparam logic [ADDR_W-1:0] ADDR_CMP2_HI  = 4'hE;
   localparam logic [ADDR_W-1:0] ADDR_CMP2_LO  = 4'hF;

   // Fields of timer_control_one.
   localparam int C1_CAP_IE  = 7;
   localparam int C1_CMP_IE  = 6;
   localparam int C1_OVF_IE  = 5;
   localparam int C1_FORCE2  = 4;
   localparam int C1_FORCE1  = 3;
   localparam int C1_LEVEL2  = 2;
   localparam int C1_EDGE1   = 1;
   localparam int C1_LEVEL1  = 0;

   // Fields of timer_control_two.
   localparam int C2_PIN1_EN = 7;
   localparam int C2_PIN2_EN = 6;
   localparam int C2_ONE_PLS = 5;
   localparam int C2_PWM     = 4;
   localparam int C2_CLK_HI  = 3;
   localparam int C2_CLK_LO  = 2;
   localparam int C2_EDGE2   = 1;
   localparam int C2_EXT_EDG = 0;

   // Fields of timer_status_flags; the flag vector holds bits 7 down to 3.
   localparam int ST_FLAG_LSB = 3;
   localparam int ST_DISABLE  = 2;
   localparam int F_CAP1      = 4;
   localparam int F_CMP1      = 3;
   localparam int F_OVF       = 2;
   localparam int F_CAP2      = 1;
   localparam int F_CMP2      = 0;

   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT  = 2'h3;
   localparam logic [2:0] DIV4_LAST = 3'h3;
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   localparam logic [DATA_W-1:0] CTRL_RESET    = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_RESET     = 16'hFFFC;
   localparam logic [CNT_W-1:0]  CNT_MAX       = 16'hFFFF;
   localparam logic [CNT_W-1:0]  CAP_OPM_VALUE = 16'hFFFD;
   localparam logic [CNT_W-1:0]  CMP_RESET     = 16'h8000;
   localparam logic [CNT_W-1:0]  CAP_RESET     = 16'h0000;

   typedef enum logic [1:0] {CCTH_MODE_NORMAL, CCTH_MODE_ONE_PULSE, CCTH_MODE_PWM} ccth_mode_t;

endpackage

// ===== test/ccth_pins_model.sv
// Far-side pin model: drives both capture pins and the external count input.
// Assumes the bench changes its requests just after rising clock edges.
module ccth_pins_model (
   input  wire logic       sys_clk_i,
   input  wire logic       ext_run_i,
   input  wire logic [1:0] cap_lvl_i,
   output logic            cap_one_o,
   output logic            cap_two_o,
   output logic            ext_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div_q = 4'h0;
   // The count clock stands low outside a burst; 16 run cycles give 4 rising and 4 falling edges.
   always_ff @(posedge sys_clk_i) begin
      div_q <= ext_run_i ? div_q + 4'h1 : 4'h0;
   end
   assign ext_o = div_q[1];
   always_ff @(posedge sys_clk_i) begin
      cap_one_o <= cap_lvl_i[0];
      cap_two_o <= cap_lvl_i[1];
   end
endmodule

// ===== test/ccth_timer_tb.sv
// Self-checking bench for the capture/compare timer, driven over its register port.
// Assumes the pin model in ccth_pins_model and the register map of ccth_pkg.
module ccth_timer_tb;
   import ccth_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 4'h0;
   logic [DATA_W-1:0] wdata_i = 8'h00;
   logic              we_i = 1'b0;
   logic              re_i = 1'b0;
   logic              halt_i = 1'b0;
   logic              irq_mask_i = 1'b0;
   logic              ext_run = 1'b0;
   logic [1:0]        cap_lvl = 2'h0;
   logic [DATA_W-1:0] rdata_o;
   logic              cap1, cap2, ext, pin1, oe1, pin2, oe2, irq_o, wake_o;
   logic [7:0]        a, b, d0;
   int                error_cnt = 0;
   int                total_checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   ccth_pins_model ccth_pins_model_i (.sys_clk_i(sys_clk_i), .ext_run_i(ext_run), .cap_lvl_i(cap_lvl),
      .cap_one_o(cap1), .cap_two_o(cap2), .ext_o(ext));
   ccth_timer ccth_timer_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .halt_i(halt_i), .irq_mask_i(irq_mask_i),
      .capture_input_one_i(cap1), .capture_input_two_i(cap2), .external_count_input_i(ext),
      .compare_output_one_o(pin1), .compare_output_one_oe_o(oe1), .compare_output_two_o(pin2),
      .compare_output_two_oe_o(oe2), .irq_o(irq_o), .wake_o(wake_o));
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i  <= ad;
      wdata_i <= d;
      we_i    <= 1'b1;
      @(posedge sys_clk_i);
      we_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the read edge, so sample just past it.
   task automatic rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= ad;
      re_i   <= 1'b1;
      @(posedge sys_clk_i);
      re_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
      logic [7:0] v;
      rd(ad, v);
      chk(v, exp);
   endtask
   task automatic wait_flag(input int n);
      logic [7:0] v;
      for (int i = 0; i < 60; i++) begin
         rd(ADDR_STATUS, v);
         if (v[n] === 1'b1) return;
      end
      error_cnt++;
      $display("ERROR at %0t: status bit %0d never set", $time, n);
      complete_run();
   endtask
   // One burst of the count clock: four edges of each polarity, then the pin rests low.
   task automatic ext_burst();
      @(posedge sys_clk_i);
      ext_run <= 1'b1;
      repeat (16) @(posedge sys_clk_i);
      ext_run <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rchk(ADDR_CTRL_ONE, 8'h00);
      rchk(ADDR_CTRL_TWO, 8'h00);
      wr(ADDR_STATUS, 8'h04);
      wr(ADDR_CNT_LO, 8'h00);
      repeat (20) @(posedge sys_clk_i);
      rchk(ADDR_CNT_HI, 8'hFF);
      rchk(ADDR_CNT_LO, 8'hFC);
      rchk(ADDR_STATUS, 8'h04);
      rchk(4'h0, 8'h00);
      $display("reset and freeze test done");
      wr(ADDR_CTRL_ONE, 8'h20);
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_CTRL_TWO, 8'h04);
      wait_flag(5);
      chk({7'h0, irq_o}, 8'h01);
      @(posedge sys_clk_i);
      irq_mask_i <= 1'b1;
      @(posedge sys_clk_i);
      chk({7'h0, irq_o}, 8'h00);
      irq_mask_i <= 1'b0;
      rd(ADDR_CNT_HI, a);
      @(posedge sys_clk_i);
      repeat (40) @(posedge sys_clk_i);
      rd(ADDR_CNT_HI, b);
      rd(ADDR_ALT_LO, a);
      @(posedge sys_clk_i);
      repeat (40) @(posedge sys_clk_i);
      rd(ADDR_ALT_LO, b);
      d0 = b - a;
      // An even gap keeps the divide-by-two phase equal for both measurements.
      @(posedge sys_clk_i);
      rd(ADDR_ALT_LO, a);
      @(posedge sys_clk_i);
      halt_i <= 1'b1;
      repeat (40) @(posedge sys_clk_i);
      chk({7'h0, wake_o}, 8'h00);
      halt_i <= 1'b0;
      rd(ADDR_ALT_LO, b);
      chk(b - a, d0 - 8'd20);
      chk({7'h0, wake_o}, 8'h01);
      rchk(ADDR_STATUS, 8'h20);
      rd(ADDR_CNT_LO, a);
      rchk(ADDR_STATUS, 8'h00);
      $display("overflow and halt test done");
      wr(ADDR_CTRL_TWO, 8'h08);
      wr(ADDR_CTRL_ONE, 8'h82);
      cap_lvl <= 2'b10;
      wr(ADDR_CNT_LO, 8'h00);
      repeat (3) @(posedge sys_clk_i);
      rchk(ADDR_STATUS, 8'h00);
      @(posedge sys_clk_i);
      cap_lvl <= 2'b01;
      repeat (3) @(posedge sys_clk_i);
      rchk(ADDR_STATUS, 8'h90);
      chk({7'h0, irq_o}, 8'h01);
      rchk(ADDR_CAP1_HI, 8'hFF);
      rd(ADDR_CAP1_LO, a);
      rd(ADDR_CAP2_LO, a);
      rchk(ADDR_STATUS, 8'h00);
      $display("capture test done");
      chk({7'h0, oe1}, 8'h00);
      wr(ADDR_CTRL_TWO, 8'hC8);
      wr(ADDR_CTRL_ONE, 8'h1D);
      repeat (2) @(posedge sys_clk_i);
      chk({6'h0, pin1, pin2}, 8'h03);
      chk({6'h0, oe1, oe2}, 8'h03);
      wr(ADDR_STATUS, 8'h04);
      @(posedge sys_clk_i);
      chk({6'h0, oe1, oe2}, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_CTRL_ONE, 8'h08);
      repeat (2) @(posedge sys_clk_i);
      chk({7'h0, pin1}, 8'h00);
      wr(ADDR_CMP1_HI, 8'hFF);
      wr(ADDR_CMP1_LO, 8'hFE);
      wr(ADDR_CTRL_ONE, 8'h41);
      wr(ADDR_CTRL_TWO, 8'hC4);
      wr(ADDR_CNT_LO, 8'h00);
      wait_flag(6);
      chk({7'h0, pin1}, 8'h01);
      chk({7'h0, irq_o}, 8'h01);
      $display("compare test done");
      wr(ADDR_CTRL_ONE, 8'h00);
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_CTRL_TWO, 8'h0C | e[7:0]);
         wr(ADDR_CNT_LO, 8'h00);
         ext_burst();
         rchk(ADDR_CNT_LO, 8'h00);
      end
      $display("external count test done");
      // The count clock rests between bursts, so the counter only moves when asked to.
      wr(ADDR_CTRL_ONE, 8'h04);
      wr(ADDR_CTRL_TWO, 8'hAD);
      cap_lvl <= 2'b00;
      repeat (3) @(posedge sys_clk_i);
      rchk(ADDR_CNT_LO, 8'hFC);
      rchk(ADDR_CAP1_LO, 8'hFD);
      chk({6'h0, pin1, oe1}, 8'h03);
      ext_burst();
      chk({7'h0, pin1}, 8'h00);
      wr(ADDR_CMP2_HI, 8'h00);
      wr(ADDR_CMP2_LO, 8'h01);
      wr(ADDR_CTRL_TWO, 8'h9D);
      ext_burst();
      rchk(ADDR_CNT_LO, 8'hFE);
      chk({7'h0, pin1}, 8'h01);
      $display("pulse modes test done");
      complete_run();
   end
endmodule
